// [hdl/cag_pkg.sv]
package cag_pkg;
  localparam int ADDR_W = 24;
  localparam int SEG_W = 8;
  localparam int PAGE_W = 10;
  localparam int PAGE_OFF_W = 14;
  localparam int WORD_W = 16;
  localparam int NUM_PAGE_PTR = 4;
  // segment kept for the on-chip boot and monitor memories
  localparam logic [7:0] BOOT_SEG = 8'hBF;
  localparam logic [15:0] BLOCKED_READ_VAL = 16'h0000;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  // reset values
  localparam logic [7:0] CODE_SEG_RST = 8'h00;
  localparam logic [9:0] PAGE_PTR_RST = 10'h000;
  localparam logic [15:0] SP_RST = 16'hFC00;
  localparam logic [7:0] STK_SEG_RST = 8'h00;
  localparam logic [15:0] STK_LOW_RST = 16'hFA00;
  localparam logic [15:0] STK_HIGH_RST = 16'hFC00;
  localparam logic [15:0] BANK_BASE_RST = 16'hFC00;
  // bank base lives in segment 0
  localparam logic [7:0] BANK_SEG = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } cag_bus_state_type;
endpackage

// [hdl/cag_stk_if.sv]
`timescale 1ns/1ps
interface cag_stk_if;
  logic push;
  logic pop;
  logic ld_sp;
  logic ld_seg;
  logic ld_low;
  logic ld_high;
  logic [15:0] wdata;
  logic [7:0] wseg;
  logic [15:0] sp;
  logic [7:0] seg;
  logic [15:0] low;
  logic [15:0] high;
  logic [23:0] op_addr;
  logic below;
  logic above;
  modport ctl (output push, pop, ld_sp, ld_seg, ld_low, ld_high, wdata, wseg,
               input sp, seg, low, high, op_addr, below, above);
  modport unit (input push, pop, ld_sp, ld_seg, ld_low, ld_high, wdata, wseg,
                output sp, seg, low, high, op_addr, below, above);
endinterface

// [hdl/cag_stack.sv]
`timescale 1ns/1ps
module cag_stack
  import cag_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  cag_stk_if.unit stk
);
  import cag_pkg::*;

  logic [15:0] sp_r, sp_nxt;
  logic [7:0] seg_r, seg_nxt;
  logic [15:0] low_r, low_nxt;
  logic [15:0] high_r, high_nxt;
  logic [15:0] push_off;

  // offset only moves; the segment is never carried into
  assign push_off = sp_r - STACK_STEP;

  // next stack state
  always_comb
  begin
    sp_nxt = sp_r;
    seg_nxt = seg_r;
    low_nxt = low_r;
    high_nxt = high_r;
    if (stk.push)
      sp_nxt = push_off; // decrement before write
    else if (stk.pop)
      sp_nxt = sp_r + STACK_STEP; // word steps only
    else if (stk.ld_sp)
      sp_nxt = stk.wdata;
    if (stk.ld_seg)
      seg_nxt = stk.wseg;
    if (stk.ld_low)
      low_nxt = stk.wdata;
    if (stk.ld_high)
      high_nxt = stk.wdata;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sp_r <= SP_RST;
      seg_r <= STK_SEG_RST;
      low_r <= STK_LOW_RST;
      high_r <= STK_HIGH_RST;
    end
    else
    begin
      sp_r <= sp_nxt;
      seg_r <= seg_nxt;
      low_r <= low_nxt;
      high_r <= high_nxt;
    end
  end

  // push targets the new top, pop reads the current top
  assign stk.op_addr = stk.push ? {seg_r, push_off} : {seg_r, sp_r};
  assign stk.sp = sp_r;
  assign stk.seg = seg_r;
  assign stk.low = low_r;
  assign stk.high = high_r;
  // limit compare only; trapping is left to the core
  assign stk.below = (sp_r < low_r);
  assign stk.above = (sp_r > high_r);
endmodule // cag_stack

// [hdl/cag_addr_gen.sv]
`timescale 1ns/1ps
module cag_addr_gen
  import cag_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_boot_mode,
  input wire logic i_emul_mode,
  input wire logic i_far_jump,
  input wire logic i_far_call,
  input wire logic i_far_ret,
  input wire logic [cag_pkg::SEG_W-1:0] i_far_seg,
  input wire logic i_fetch_req,
  input wire logic [cag_pkg::WORD_W-1:0] i_fetch_off,
  output logic [cag_pkg::ADDR_W-1:0] o_fetch_addr,
  output logic o_fetch_valid,
  output logic [cag_pkg::SEG_W-1:0] o_code_segment_pointer,
  input wire logic i_page_ptr_we,
  input wire logic [1:0] i_page_ptr_sel,
  input wire logic [cag_pkg::PAGE_W-1:0] i_page_ptr_wdata,
  output logic [cag_pkg::NUM_PAGE_PTR*cag_pkg::PAGE_W-1:0] o_page_pointer_set,
  input wire logic i_data_req,
  input wire logic i_data_we,
  input wire logic i_data_byte,
  input wire logic [cag_pkg::WORD_W-1:0] i_data_off,
  input wire logic i_data_seg_ovr,
  input wire logic [cag_pkg::SEG_W-1:0] i_data_seg,
  input wire logic [cag_pkg::WORD_W-1:0] i_data_wdata,
  output logic o_data_ready,
  output logic o_data_rvalid,
  output logic [cag_pkg::WORD_W-1:0] o_data_rdata,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [cag_pkg::WORD_W-1:0] i_push_data,
  output logic o_stack_ready,
  input wire logic i_sp_we,
  input wire logic i_stk_seg_we,
  input wire logic i_stk_low_we,
  input wire logic i_stk_high_we,
  input wire logic [cag_pkg::WORD_W-1:0] i_stk_wdata,
  input wire logic [cag_pkg::SEG_W-1:0] i_stk_seg_wdata,
  output logic [cag_pkg::WORD_W-1:0] o_stack_offset_reg,
  output logic [cag_pkg::SEG_W-1:0] o_stack_segment_reg,
  output logic [cag_pkg::WORD_W-1:0] o_stack_low_limit,
  output logic [cag_pkg::WORD_W-1:0] o_stack_high_limit,
  output logic o_stack_below_low,
  output logic o_stack_above_high,
  input wire logic i_bank_base_we,
  input wire logic [cag_pkg::WORD_W-1:0] i_bank_base_wdata,
  input wire logic i_switch_ctx,
  output logic [cag_pkg::WORD_W-1:0] o_bank_base_pointer,
  input wire logic i_gpr_req,
  input wire logic i_gpr_byte,
  input wire logic [3:0] i_gpr_num,
  input wire logic [3:0] i_gpr_bit,
  output logic o_gpr_valid,
  output logic [cag_pkg::ADDR_W-1:0] o_gpr_addr,
  output logic [3:0] o_gpr_bit,
  output logic o_bus_req,
  output logic o_bus_we,
  output logic o_bus_byte,
  output logic o_bus_onchip,
  output logic [cag_pkg::ADDR_W-1:0] o_bus_addr,
  output logic [cag_pkg::WORD_W-1:0] o_bus_wdata,
  input wire logic i_bus_done,
  input wire logic [cag_pkg::WORD_W-1:0] i_bus_rdata
);
  import cag_pkg::*;

  cag_stk_if stk ();

  cag_stack u_stack (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .stk(stk)
  );

  logic [SEG_W-1:0] code_seg_r, code_seg_nxt;
  logic [PAGE_W-1:0] page_ptr_r [NUM_PAGE_PTR];
  logic [PAGE_W-1:0] page_ptr_nxt [NUM_PAGE_PTR];
  logic [WORD_W-1:0] bank_base_r, bank_base_nxt;
  cag_bus_state_type state_r, state_nxt;
  logic idle;
  logic stack_op;
  logic stack_take;
  logic data_take;
  logic [ADDR_W-1:0] data_addr;
  logic [ADDR_W-1:0] req_addr;
  logic req_we;
  logic [WORD_W-1:0] req_wdata;
  logic boot_hit;
  logic boot_open;
  logic bus_req_r, bus_req_nxt;
  logic bus_we_r, bus_we_nxt;
  logic bus_byte_r, bus_byte_nxt;
  logic bus_onchip_r, bus_onchip_nxt;
  logic [ADDR_W-1:0] bus_addr_r, bus_addr_nxt;
  logic [WORD_W-1:0] bus_wdata_r, bus_wdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [WORD_W-1:0] rdata_r, rdata_nxt;
  logic fetch_valid_r, fetch_valid_nxt;
  logic [ADDR_W-1:0] fetch_addr_r, fetch_addr_nxt;
  logic gpr_valid_r, gpr_valid_nxt;
  logic [ADDR_W-1:0] gpr_addr_r, gpr_addr_nxt;
  logic [3:0] gpr_bit_r, gpr_bit_nxt;
  logic [WORD_W-1:0] gpr_off;

  // one access in flight; stack work outranks plain data
  assign idle = (state_r == ST_IDLE);
  assign stack_op = i_push | i_pop | i_switch_ctx;
  assign o_stack_ready = idle;
  assign o_data_ready = idle & ~stack_op;
  assign stack_take = idle & stack_op;
  assign data_take = idle & ~stack_op & i_data_req;

  // stack unit control; a context switch pushes the old base
  assign stk.push = stack_take & (i_push | i_switch_ctx);
  assign stk.pop = stack_take & i_pop & ~i_push & ~i_switch_ctx;
  assign stk.ld_sp = i_sp_we & ~stack_take;
  assign stk.ld_seg = i_stk_seg_we;
  assign stk.ld_low = i_stk_low_we;
  assign stk.ld_high = i_stk_high_we;
  assign stk.wdata = i_stk_wdata;
  assign stk.wseg = i_stk_seg_wdata;

  // data address: explicit segment wins over the page pointers
  always_comb
  begin
    if (i_data_seg_ovr)
      data_addr = {i_data_seg, i_data_off};
    else
      data_addr = {page_ptr_r[i_data_off[15:14]], i_data_off[PAGE_OFF_W-1:0]};
  end

  // pick the access that goes to the bus this cycle
  always_comb
  begin
    if (stack_take)
    begin
      req_addr = stk.op_addr;
      req_we = ~stk.pop;
      req_wdata = (i_switch_ctx & ~i_push) ? bank_base_r : i_push_data; // a push outranks a switch
    end
    else
    begin
      req_addr = data_addr;
      req_we = i_data_we;
      req_wdata = i_data_wdata;
    end
  end

  // segment 191 is closed unless a special mode is on
  assign boot_hit = (req_addr[ADDR_W-1:WORD_W] == BOOT_SEG);
  assign boot_open = i_boot_mode | i_emul_mode;

  // bus state and read return
  always_comb
  begin
    state_nxt = state_r;
    bus_req_nxt = bus_req_r;
    bus_we_nxt = bus_we_r;
    bus_byte_nxt = bus_byte_r;
    bus_onchip_nxt = bus_onchip_r;
    bus_addr_nxt = bus_addr_r;
    bus_wdata_nxt = bus_wdata_r;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      ST_IDLE:
      begin
        if (stack_take | data_take)
        begin
          if (boot_hit && !boot_open)
          begin
            // no bus cycle at all; a read answers with the fixed value
            rvalid_nxt = ~req_we;
            rdata_nxt = BLOCKED_READ_VAL;
          end
          else
          begin
            state_nxt = ST_WAIT;
            bus_req_nxt = 1'b1;
            bus_we_nxt = req_we;
            bus_byte_nxt = stack_take ? 1'b0 : i_data_byte;
            bus_onchip_nxt = boot_hit; // keeps pins quiet
            bus_addr_nxt = req_addr;
            bus_wdata_nxt = req_wdata;
          end
        end
      end
      ST_WAIT:
      begin
        if (i_bus_done)
        begin
          state_nxt = ST_IDLE;
          bus_req_nxt = 1'b0;
          rvalid_nxt = ~bus_we_r;
          rdata_nxt = bus_we_r ? rdata_r : i_bus_rdata;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        bus_req_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r <= ST_IDLE;
      bus_req_r <= 1'b0;
      bus_we_r <= 1'b0;
      bus_byte_r <= 1'b0;
      bus_onchip_r <= 1'b0;
      bus_addr_r <= '0;
      bus_wdata_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      bus_req_r <= bus_req_nxt;
      bus_we_r <= bus_we_nxt;
      bus_byte_r <= bus_byte_nxt;
      bus_onchip_r <= bus_onchip_nxt;
      bus_addr_r <= bus_addr_nxt;
      bus_wdata_r <= bus_wdata_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // code segment pointer and fetch address; no carry out of the offset
  always_comb
  begin
    code_seg_nxt = code_seg_r;
    if (i_far_jump | i_far_call | i_far_ret)
      code_seg_nxt = i_far_seg;
    fetch_valid_nxt = i_fetch_req;
    fetch_addr_nxt = i_fetch_req ? {code_seg_r, i_fetch_off} : fetch_addr_r;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      code_seg_r <= CODE_SEG_RST;
      fetch_valid_r <= 1'b0;
      fetch_addr_r <= '0;
    end
    else
    begin
      code_seg_r <= code_seg_nxt;
      fetch_valid_r <= fetch_valid_nxt;
      fetch_addr_r <= fetch_addr_nxt;
    end
  end

  // page pointers, one per quarter of the 16-bit data space
  for (genvar g = 0; g < NUM_PAGE_PTR; g++)
  begin : g_page
    always_comb
    begin
      page_ptr_nxt[g] = page_ptr_r[g];
      if (i_page_ptr_we && (i_page_ptr_sel == 2'(g)))
        page_ptr_nxt[g] = i_page_ptr_wdata;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        page_ptr_r[g] <= PAGE_PTR_RST;
      else
        page_ptr_r[g] <= page_ptr_nxt[g];
    end

    assign o_page_pointer_set[g*PAGE_W +: PAGE_W] = page_ptr_r[g];
  end

  // word n at base+2n; byte code {n, high} lands on even/odd byte
  always_comb
  begin
    if (i_gpr_byte)
      gpr_off = {12'h000, i_gpr_num}; // code {n, high} is the byte offset
    else
      gpr_off = {11'h000, i_gpr_num, 1'b0};
  end

  // bank base; a switch loads the new base in the same cycle it saves
  always_comb
  begin
    bank_base_nxt = bank_base_r;
    if (i_switch_ctx && !i_push && stack_take)
      bank_base_nxt = i_bank_base_wdata;
    else if (i_bank_base_we)
      bank_base_nxt = i_bank_base_wdata;
    gpr_valid_nxt = i_gpr_req;
    gpr_addr_nxt = i_gpr_req ? {BANK_SEG, bank_base_r + gpr_off} : gpr_addr_r; // no page pointer involved
    gpr_bit_nxt = i_gpr_req ? i_gpr_bit : gpr_bit_r;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bank_base_r <= BANK_BASE_RST;
      gpr_valid_r <= 1'b0;
      gpr_addr_r <= '0;
      gpr_bit_r <= '0;
    end
    else
    begin
      bank_base_r <= bank_base_nxt;
      gpr_valid_r <= gpr_valid_nxt;
      gpr_addr_r <= gpr_addr_nxt;
      gpr_bit_r <= gpr_bit_nxt;
    end
  end

  // outputs; local banks have no path here at all
  assign o_fetch_addr = fetch_addr_r;
  assign o_fetch_valid = fetch_valid_r;
  assign o_code_segment_pointer = code_seg_r;
  assign o_data_rvalid = rvalid_r;
  assign o_data_rdata = rdata_r;
  assign o_stack_offset_reg = stk.sp;
  assign o_stack_segment_reg = stk.seg;
  assign o_stack_low_limit = stk.low;
  assign o_stack_high_limit = stk.high;
  assign o_stack_below_low = stk.below;
  assign o_stack_above_high = stk.above;
  assign o_bank_base_pointer = bank_base_r;
  assign o_gpr_valid = gpr_valid_r;
  assign o_gpr_addr = gpr_addr_r;
  assign o_gpr_bit = gpr_bit_r;
  assign o_bus_req = bus_req_r;
  assign o_bus_we = bus_we_r;
  assign o_bus_byte = bus_byte_r;
  assign o_bus_onchip = bus_onchip_r;
  assign o_bus_addr = bus_addr_r;
  assign o_bus_wdata = bus_wdata_r;
endmodule // cag_addr_gen

// [sim/cag_checker.sv]
`timescale 1ns/1ps
module cag_chk
  import cag_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_far_jump,
  input wire logic i_far_call,
  input wire logic i_far_ret,
  input wire logic [7:0] i_far_seg,
  input wire logic i_fetch_req,
  input wire logic [15:0] i_fetch_off,
  input wire logic [23:0] o_fetch_addr,
  input wire logic o_fetch_valid,
  input wire logic [7:0] o_code_segment_pointer,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_switch_ctx,
  input wire logic o_stack_ready,
  input wire logic [15:0] o_stack_offset_reg,
  input wire logic [7:0] o_stack_segment_reg,
  input wire logic o_bus_req,
  input wire logic o_bus_we,
  input wire logic o_bus_byte,
  input wire logic o_bus_onchip,
  input wire logic [23:0] o_bus_addr,
  input wire logic i_bus_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // fetch address built from the pointer as it stood before any same-cycle far load
  AST_FETCH: assert property (i_fetch_req |=> o_fetch_valid && o_fetch_addr ==
    {$past(o_code_segment_pointer), $past(i_fetch_off)}) else $error("fetch address wrong");
  AST_CODE_SEG_HOLD: assert property (!(i_far_jump || i_far_call || i_far_ret) |=>
    $stable(o_code_segment_pointer)) else $error("code segment moved without far branch");
  AST_CODE_SEG_LOAD: assert property ((i_far_jump || i_far_call || i_far_ret) |=>
    o_code_segment_pointer == $past(i_far_seg)) else $error("far branch did not load segment");
  AST_BOOT_ONCHIP: assert property (o_bus_req && o_bus_addr[23:16] == BOOT_SEG |-> o_bus_onchip)
    else $error("boot segment access reached pins");
  // push writes one word below the old pointer and leaves the pointer there
  AST_PUSH: assert property (i_push && o_stack_ready && o_stack_segment_reg != BOOT_SEG |=>
    o_bus_req && o_bus_we && !o_bus_byte
    && o_bus_addr == {$past(o_stack_segment_reg), $past(o_stack_offset_reg) - STACK_STEP}
    && o_stack_offset_reg == $past(o_stack_offset_reg) - STACK_STEP) else $error("push wrong");
  AST_POP: assert property (i_pop && !i_push && !i_switch_ctx && o_stack_ready
    && o_stack_segment_reg != BOOT_SEG |=> o_bus_req && !o_bus_we
    && !o_bus_byte && o_bus_addr == {$past(o_stack_segment_reg), $past(o_stack_offset_reg)}
    && o_stack_offset_reg == $past(o_stack_offset_reg) + STACK_STEP) else $error("pop wrong");
  AST_STK_SEG: assert property ((i_push || i_pop) && o_stack_ready |=>
    $stable(o_stack_segment_reg)) else $error("stack op touched segment");
  AST_BUS_HOLD: assert property (o_bus_req && !i_bus_done |=> o_bus_req && $stable(o_bus_addr)
    && $stable(o_bus_byte)) else $error("bus request dropped early");
endmodule // cag_chk
bind cag_addr_gen cag_chk cag_chk_i (.i_clk, .i_arst_n, .i_far_jump, .i_far_call, .i_far_ret, .i_far_seg,
  .i_fetch_req, .i_fetch_off, .o_fetch_addr, .o_fetch_valid, .o_code_segment_pointer, .i_push, .i_pop,
  .i_switch_ctx, .o_stack_ready, .o_stack_offset_reg, .o_stack_segment_reg, .o_bus_req, .o_bus_we,
  .o_bus_byte, .o_bus_onchip, .o_bus_addr, .i_bus_done);

// [sim/cag_mem_model.sv]
`timescale 1ns/1ps
module cag_mem_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_slow,
  output logic o_done,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:255];
  logic wait_r;
  // answers at once or after one wait; data line toggles when not answering
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_done <= 1'b0;
      wait_r <= 1'b0;
      o_rdata <= 16'hA5A5;
    end
    else if (i_req && !o_done && (wait_r || !i_slow))
    begin
      o_done <= 1'b1;
      wait_r <= 1'b0;
      o_rdata <= mem[i_addr[8:1]];
      if (i_we)
        mem[i_addr[8:1]] <= i_wdata;
    end
    else
    begin
      o_done <= 1'b0;
      wait_r <= i_req && !o_done;
      o_rdata <= ~o_rdata;
    end
  end
endmodule // cag_mem_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import cag_pkg::*;
  logic i_clk, i_arst_n, i_boot_mode, i_emul_mode, i_far_jump, i_far_call, i_far_ret, i_fetch_req, i_page_ptr_we;
  logic i_data_req, i_data_we, i_data_byte, i_data_seg_ovr, i_push, i_pop, i_sp_we, i_stk_seg_we, i_stk_low_we;
  logic i_stk_high_we, i_bank_base_we, i_switch_ctx, i_gpr_req, i_gpr_byte, i_bus_done, lat, oc, bq, bb;
  logic o_fetch_valid, o_data_ready, o_data_rvalid, o_stack_ready, o_stack_below_low, o_stack_above_high;
  logic o_gpr_valid, o_bus_req, o_bus_we, o_bus_byte, o_bus_onchip;
  logic [1:0] i_page_ptr_sel;
  logic [3:0] i_gpr_num, i_gpr_bit, o_gpr_bit;
  logic [7:0] i_far_seg, i_data_seg, i_stk_seg_wdata, o_code_segment_pointer, o_stack_segment_reg;
  logic [9:0] i_page_ptr_wdata;
  logic [15:0] i_fetch_off, i_data_off, i_data_wdata, i_push_data, i_stk_wdata, i_bank_base_wdata, i_bus_rdata, rd;
  logic [15:0] o_data_rdata, o_stack_offset_reg, o_stack_low_limit, o_stack_high_limit, o_bank_base_pointer;
  logic [15:0] o_bus_wdata, bw;
  logic [23:0] o_fetch_addr, o_gpr_addr, o_bus_addr, ba;
  logic [39:0] o_page_pointer_set;
  int bad_count, n_compared;
  cag_addr_gen cag_addr_gen_i (.i_clk, .i_arst_n, .i_boot_mode, .i_emul_mode, .i_far_jump, .i_far_call,
    .i_far_ret, .i_far_seg, .i_fetch_req, .i_fetch_off, .o_fetch_addr, .o_fetch_valid, .o_code_segment_pointer,
    .i_page_ptr_we, .i_page_ptr_sel, .i_page_ptr_wdata, .o_page_pointer_set, .i_data_req, .i_data_we, .i_data_byte,
    .i_data_off, .i_data_seg_ovr, .i_data_seg, .i_data_wdata, .o_data_ready, .o_data_rvalid, .o_data_rdata,
    .i_push, .i_pop, .i_push_data, .o_stack_ready, .i_sp_we, .i_stk_seg_we, .i_stk_low_we, .i_stk_high_we,
    .i_stk_wdata, .i_stk_seg_wdata, .o_stack_offset_reg, .o_stack_segment_reg, .o_stack_low_limit,
    .o_stack_high_limit, .o_stack_below_low, .o_stack_above_high, .i_bank_base_we, .i_bank_base_wdata, .i_switch_ctx,
    .o_bank_base_pointer, .i_gpr_req, .i_gpr_byte, .i_gpr_num, .i_gpr_bit, .o_gpr_valid, .o_gpr_addr,
    .o_gpr_bit, .o_bus_req, .o_bus_we, .o_bus_byte, .o_bus_onchip, .o_bus_addr, .o_bus_wdata, .i_bus_done,
    .i_bus_rdata);
  cag_mem_model cag_mem_model_i (.i_clk, .i_arst_n, .i_req(o_bus_req), .i_we(o_bus_we), .i_addr(o_bus_addr),
    .i_wdata(o_bus_wdata), .i_slow(lat), .o_done(i_bus_done), .o_rdata(i_bus_rdata));
  always #5 i_clk = ~i_clk;
  task automatic chk(input logic [63:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one transfer, c = push pop switch req we ovr; waits for idle, data reads need their answer too
  task automatic xfer(input logic [5:0] c, input logic [7:0] sg, input logic [15:0] off, wd);
    int k;
    @(negedge i_clk);
    {i_push, i_pop, i_switch_ctx, i_data_req, i_data_we, i_data_seg_ovr} = c;
    {i_data_seg, i_data_off, i_data_wdata, i_push_data, i_bank_base_wdata} = {sg, off, wd, wd, wd};
    rd = 'x;
    {ba, bw, oc, bq, bb} = '0;
    for (k = 0; k < 20; k++)
    begin
      @(negedge i_clk);
      {i_push, i_pop, i_switch_ctx, i_data_req} = 4'h0;
      if (k == 0 && o_bus_req === 1'b1)
        chk({o_data_ready, o_stack_ready}, 2'b00);
      if (o_bus_req === 1'b1)
        {ba, bw, oc, bq, bb} = {o_bus_addr, o_bus_wdata, o_bus_onchip, 1'b1, o_bus_byte};
      if (o_data_rvalid === 1'b1)
        rd = o_data_rdata;
      if (k > 0 && o_stack_ready === 1'b1 && o_bus_req === 1'b0 && (c[2:1] != 2'b10 || rd !== 16'hxxxx))
        break;
    end
    if (k == 20)
    begin
      bad_count++;
      $display("CHECK FAILED %0t transfer hung", $time);
      end_sim;
    end
  endtask
  // far loads issued from the top offset; the last fetch has no far load
  task automatic t_fetch;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge i_clk);
      {i_far_jump, i_far_call, i_far_ret, i_fetch_req} = {3'h4 >> i, 1'b1};
      {i_far_seg, i_fetch_off} = {8'h10 + 8'(i), 16'hFFFE};
      @(negedge i_clk);
      {i_far_jump, i_far_call, i_far_ret, i_fetch_req} = 4'h0;
      chk({o_fetch_valid, o_fetch_addr}, {1'b1, (i == 0 ? CODE_SEG_RST : 8'h0F + 8'(i)), 16'hFFFE});
      chk(o_code_segment_pointer, i == 3 ? 8'h12 : 8'h10 + 8'(i));
    end
  endtask
  // pages three apart so neighbouring offsets land far apart; slow memory
  task automatic t_pages;
    logic [15:0] off;
    for (int g = 0; g < 4; g++)
    begin
      @(negedge i_clk);
      {i_page_ptr_we, i_page_ptr_sel, i_page_ptr_wdata} = {1'b1, 2'(g), 10'(16'h40 + 3 * g)};
    end
    @(negedge i_clk);
    {i_page_ptr_we, lat} = 2'b01;
    chk(o_page_pointer_set, {10'h049, 10'h046, 10'h043, 10'h040});
    for (int k = 0; k < 5; k++)
    begin
      off = k == 4 ? 16'h4000 : {2'(k), 14'h3FFE};
      xfer(6'h06, 8'h00, off, off ^ 16'h5A5A);
      chk(ba, {10'h040 + 10'(3 * off[15:14]), off[13:0]});
      xfer(6'h04, 8'h00, off, 16'h0000);
      chk(rd, off ^ 16'h5A5A);
    end
    lat = 1'b0;
  endtask
  // boot segment shut in normal mode, open in boot and in emulation mode
  task automatic t_boot;
    xfer(6'h07, BOOT_SEG, 16'h0010, 16'h1234);
    chk(bq, 1'b0);
    xfer(6'h05, BOOT_SEG, 16'h0010, 16'h0000);
    chk({bq, rd}, {1'b0, BLOCKED_READ_VAL});
    i_boot_mode = 1'b1;
    xfer(6'h07, BOOT_SEG, 16'h0010, 16'h1234);
    chk({bq, oc, ba}, {2'b11, BOOT_SEG, 16'h0010});
    {i_boot_mode, i_emul_mode} = 2'b01;
    xfer(6'h05, BOOT_SEG, 16'h0010, 16'h0000);
    chk({oc, rd}, {1'b1, 16'h1234});
    {i_emul_mode, i_data_byte} = 2'b01;
    xfer(6'h05, 8'h22, 16'h0010, 16'h0000);
    chk({oc, bb, ba}, {2'b01, 8'h22, 16'h0010});
  endtask
  // two pushes, the second past the low limit, a pop, then a push that wraps within the segment
  task automatic t_stack;
    chk({o_stack_low_limit, o_stack_high_limit, o_stack_offset_reg}, {STK_LOW_RST, STK_HIGH_RST, SP_RST});
    @(negedge i_clk);
    {i_sp_we, i_stk_seg_we, i_stk_wdata, i_stk_seg_wdata} = {2'b11, 16'h0100, 8'h03};
    @(negedge i_clk);
    {i_sp_we, i_stk_seg_we, i_stk_low_we, i_stk_wdata} = {3'b001, 16'h00FE};
    @(negedge i_clk);
    i_stk_low_we = 1'b0;
    xfer(6'h20, 8'h00, 16'h0000, 16'hA001);
    chk({ba, bb, o_stack_offset_reg, o_stack_below_low}, {24'h0300FE, 1'b0, 16'h00FE, 1'b0});
    xfer(6'h20, 8'h00, 16'h0000, 16'hA002);
    chk({ba, bw, o_stack_below_low}, {24'h0300FC, 16'hA002, 1'b1});
    xfer(6'h10, 8'h00, 16'h0000, 16'h0000);
    chk({ba, o_stack_offset_reg, rd}, {24'h0300FC, 16'h00FE, 16'hA002});
    {i_sp_we, i_stk_wdata} = {1'b1, 16'h0000};
    @(negedge i_clk);
    i_sp_we = 1'b0;
    xfer(6'h20, 8'h00, 16'h0000, 16'hA003);
    chk({ba, o_stack_segment_reg, o_stack_above_high}, {24'h03FFFE, 8'h03, 1'b1});
    {i_stk_high_we, i_stk_wdata} = {1'b1, 16'hFFFF};
    @(negedge i_clk);
    i_stk_high_we = 1'b0;
    chk({o_stack_high_limit, o_stack_above_high}, {16'hFFFF, 1'b0});
  endtask
  // every word and byte register of a new bank, then a context switch
  task automatic t_bank;
    @(negedge i_clk);
    {i_bank_base_we, i_bank_base_wdata} = {1'b1, 16'h0100};
    for (int n = 0; n < 32; n++)
    begin
      @(negedge i_clk);
      {i_bank_base_we, i_gpr_req, i_gpr_byte, i_gpr_num, i_gpr_bit} = {2'b01, 5'(n), 4'(n)};
      @(negedge i_clk);
      i_gpr_req = 1'b0;
      chk({o_gpr_valid, o_gpr_bit, o_gpr_addr}, {1'b1, 4'(n), BANK_SEG,
        16'h0100 + (n > 15 ? 16'(n - 16) : 16'(2 * n))});
    end
    xfer(6'h08, 8'h00, 16'h0000, 16'h0200);
    chk({o_bank_base_pointer, bw, ba}, {16'h0200, 16'h0100, 24'h03FFFC});
  endtask
  initial
  begin
    {i_clk, i_arst_n, lat, i_boot_mode, i_emul_mode, i_far_jump, i_far_call, i_far_ret, i_fetch_req} = '0;
    {i_page_ptr_we, i_data_req, i_data_we, i_data_byte, i_data_seg_ovr, i_push, i_pop, i_sp_we, i_stk_seg_we} = '0;
    {i_stk_low_we, i_stk_high_we, i_bank_base_we, i_switch_ctx, i_gpr_req, i_gpr_byte, i_page_ptr_sel} = '0;
    {i_gpr_num, i_gpr_bit, i_far_seg, i_data_seg, i_stk_seg_wdata, i_page_ptr_wdata, i_fetch_off, i_data_off} = '0;
    {i_data_wdata, i_push_data, i_stk_wdata, i_bank_base_wdata} = '0;
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_arst_n = 1'b1;
    chk({o_page_pointer_set, o_bank_base_pointer}, {{4{PAGE_PTR_RST}}, BANK_BASE_RST});
    t_fetch;
    t_pages;
    t_boot;
    t_stack;
    t_bank;
    end_sim;
  end
endmodule // testbench
